// *** core/dual_serial_port.sv ***
// Two synchronous serial ports with AXI4-Lite registers and a tx FIFO.
// Assumes link pins arrive asynchronously; pads resolve the enables.
// What this block does
// - Two independent synchronous serial ports, usable for plain and multiprocessor links.
// - Each port has own tx and rx sections, each double-buffered.
// - Serial clock either taken from the pin or generated at programmable rate.
// - Tx and rx sections of a port have independent framing settings, except port A in multichannel mode, where tx uses the rx settings.
// - Each section runs unframed, or with internal or external frame sync.
// - Frame sync polarity selectable; normal or late sync with two widths.
// - Word length programmable from 1 to 16 bits for tx and rx.
// - Optional A-law or mu-law compression on tx, expansion on rx.
// - Tx and rx sections each raise their own word-done interrupt.
// - Autobuffer counts a repeating run of words; each word still passes through the registers.
// - In autobuffer mode interrupt comes once the whole run completes.
// - Port A multichannel mode picks slots within 24- or 32-word frames.
// - Port B pins can become two interrupt inputs and in/out flags.
// - Internal serial clock of port B stays usable in that pin mode.
// - Pin functions may be changed by software at any time.
// - Flag and interrupt functions on shared pins work concurrently.
`timescale 1ns/1ps

module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp;
  logic [AW:0] count;
  logic push, pop;

  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module dual_serial_port #(
  parameter int TX_FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Link pins, index 0 is port A
  input wire serial_port_pkg::link_sense_t [1:0] link_sense,
  output serial_port_pkg::link_drive_t [1:0] link_drive,
  // Events, index 0 A tx, 1 A rx, 2 B tx, 3 B rx
  output logic [3:0] word_irq,
  output logic ext_interrupt_line_zero,
  output logic ext_interrupt_line_one
);
  import serial_port_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] b);
    for (int i = 0; i < 4; i++) begin
      if (b[i]) o[i*8 +: 8] = n[i*8 +: 8];
    end
    return o;
  endfunction

  function automatic logic [7:0] compress(input logic [15:0] x, input logic alaw);
    logic neg;
    logic [15:0] m;
    logic [2:0] e;
    logic [3:0] t;
    neg = x[15];
    m = neg ? ~x : x;
    e = 3'h0;
    if (!alaw) begin
      m = m >> 2;
      if (m > 16'h1fde) m = 16'h1fde;
      m = m + 16'h0021;
      for (int i = 0; i < 8; i++) begin
        if (m[i+5]) e = 3'(i);
      end
      t = 4'(m >> (4'(e) + 4'h1));
      return {~neg, ~e, ~t};
    end
    m = m >> 3;
    for (int i = 0; i < 7; i++) begin
      if (m[i+5]) e = 3'(i + 1);
    end
    t = (e == 3'h0) ? m[4:1] : 4'(m >> e);
    return {~neg, e, t} ^ 8'h55;
  endfunction

  function automatic logic [15:0] expand(input logic [7:0] c, input logic alaw);
    logic [7:0] v;
    logic [15:0] t;
    if (!alaw) begin
      v = ~c;
      t = ({12'h000, v[3:0]} << 3) + 16'h0084;
      t = (t << v[6:4]) - 16'h0084;
      return v[7] ? ~t + 16'h0001 : t;
    end
    v = c ^ 8'h55;
    t = {8'h00, v[3:0], 4'h8};
    if (v[6:4] != 3'h0) t = (t + 16'h0100) << (v[6:4] - 3'h1);
    return v[7] ? t : ~t + 16'h0001;
  endfunction

  // Registers
  logic [31:0] ctrl [2];
  logic [15:0] div [2];
  logic [31:0] mc_tx, mc_rx;
  logic [15:0] ablen;
  logic flag_out;
  // AXI state
  logic aw_got, w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire, wr_ok, rd_fire, rd_ok;
  logic [31:0] rd_word;
  // Pin sampling and serial clocks
  logic [7:0] s1, s2, s3, filt;
  logic [15:0] div_cnt [2];
  logic [1:0] sclk_int, sclk_q, lvl, rise, fall;
  // Sections
  sec_state_t st [4];
  logic [3:0] bitc [4];
  logic [15:0] sh [4];
  logic [15:0] hold [4];
  logic [3:0] hold_v, fs_drv, fin, go, frm, mc;
  logic [8:0] cf [4];
  logic [3:0] wl [4];
  logic [7:0] abc [4];
  logic [4:0] slot;
  // Tx FIFO of port A
  logic fifo_in_ready, fifo_out_valid;
  logic [15:0] fifo_out_data;

  sync_fifo #(.WIDTH(16), .DEPTH(TX_FIFO_DEPTH)) tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(wr_fire && aw_addr == OFS_TX_A),
    .in_data(w_data[15:0]),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(!hold_v[0])
  );

  // Write waits while the FIFO is full
  assign wr_fire = aw_got & w_got & ~bvalid & (aw_addr != OFS_TX_A | fifo_in_ready);
  assign wr_ok = aw_addr <= OFS_FLAG;
  assign rd_fire = arvalid & arready;

  always_comb begin
    rd_ok = 1'b1;
    case ({araddr[7:2], 2'b00})
      OFS_CTRL_A: rd_word = ctrl[0];
      OFS_CTRL_B: rd_word = ctrl[1];
      OFS_DIV_A: rd_word = {16'h0000, div[0]};
      OFS_DIV_B: rd_word = {16'h0000, div[1]};
      OFS_RX_A: rd_word = {16'h0000, hold[1]};
      OFS_RX_B: rd_word = {16'h0000, hold[3]};
      OFS_STAT: rd_word = {11'h000, slot, 4'h0, ext_interrupt_line_one,
                           ext_interrupt_line_zero, filt[4+B_DAT], ~fifo_in_ready,
                           hold_v, fs_drv};
      OFS_MC_TX: rd_word = mc_tx;
      OFS_MC_RX: rd_word = mc_rx;
      OFS_ABLEN: rd_word = {16'h0000, ablen};
      OFS_FLAG: rd_word = {31'h0, flag_out};
      OFS_TX_A, OFS_TX_B: rd_word = 32'h0000_0000;
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Register bus slave; configuration may change at any time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
      ctrl[0] <= CTRL_RST;
      ctrl[1] <= CTRL_RST;
      div[0] <= DIV_RST;
      div[1] <= DIV_RST;
      mc_tx <= 32'h0000_0000;
      mc_rx <= 32'h0000_0000;
      ablen <= 16'h0000;
      flag_out <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_addr <= {awaddr[7:2], 2'b00};
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
        wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
        bvalid <= 1'b1;
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        case (aw_addr)
          OFS_CTRL_A: ctrl[0] <= merge(ctrl[0], w_data, w_strb);
          OFS_CTRL_B: ctrl[1] <= merge(ctrl[1], w_data, w_strb);
          OFS_DIV_A: div[0] <= 16'(merge({16'h0000, div[0]}, w_data, w_strb));
          OFS_DIV_B: div[1] <= 16'(merge({16'h0000, div[1]}, w_data, w_strb));
          OFS_MC_TX: mc_tx <= merge(mc_tx, w_data, w_strb);
          OFS_MC_RX: mc_rx <= merge(mc_rx, w_data, w_strb);
          OFS_ABLEN: ablen <= 16'(merge({16'h0000, ablen}, w_data, w_strb));
          OFS_FLAG: flag_out <= w_strb[0] ? w_data[0] : flag_out;
          default: ;
        endcase
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (rd_fire) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Pin inputs: three stages, a change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 8'h00;
      s2 <= 8'h00;
      s3 <= 8'h00;
      filt <= 8'h00;
    end else begin
      s1 <= link_sense;
      s2 <= s1;
      s3 <= s2;
      filt <= (s2 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
    end
  end

  // Serial clock per port: divider or sensed pin
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      lvl[p] = ctrl[p][F_ISCLK] ? sclk_int[p] : filt[p*4+B_CLK];
      rise[p] = lvl[p] & ~sclk_q[p];
      fall[p] = ~lvl[p] & sclk_q[p];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt[0] <= 16'h0000;
      div_cnt[1] <= 16'h0000;
      sclk_int <= 2'b00;
      sclk_q <= 2'b00;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (div_cnt[p] >= div[p]) begin
          div_cnt[p] <= 16'h0000;
          sclk_int[p] <= ~sclk_int[p];
        end else begin
          div_cnt[p] <= div_cnt[p] + 16'h0001;
        end
        sclk_q[p] <= lvl[p];
      end
    end
  end

  // Per-section settings and start condition
  always_comb begin
    for (int s = 0; s < 4; s++) begin
      mc[s] = (s < 2) && ctrl[0][F_ALT];
      cf[s] = mc[s] ? ctrl[0][SEC_W +: SEC_W] : ctrl[s/2][(s%2)*SEC_W +: SEC_W];
      wl[s] = ctrl[s/2][F_CMP+1] ? WL_COMPAND : cf[s][F_WL +: 4];
      frm[s] = cf[s][F_FRM] && !(mc[s] && slot != 5'h00);
      go[s] = cf[s][F_EN] && !(s >= 2 && ctrl[1][F_ALT]) &&
              ((s%2 == 1) || mc[s] || hold_v[s]) &&
              (!frm[s] || cf[s][F_IFS] ||
               ((mc[s] ? filt[B_RXS] : filt[(s/2)*4+B_TXS-(s%2)]) ^ cf[s][F_INV]));
    end
  end

  // Section engines: tx shifts on rising, rx samples on falling serial clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int s = 0; s < 4; s++) begin
        st[s] <= ST_IDLE;
        bitc[s] <= 4'h0;
        sh[s] <= 16'h0000;
        hold[s] <= 16'h0000;
      end
      hold_v <= 4'h0;
      fs_drv <= 4'h0;
      fin <= 4'h0;
      slot <= 5'h00;
    end else begin
      fin <= 4'h0;
      if (!hold_v[0] && fifo_out_valid) begin
        hold[0] <= fifo_out_data;
        hold_v[0] <= 1'b1;
      end
      if (rd_fire && {araddr[7:2], 2'b00} == OFS_RX_A) hold_v[1] <= 1'b0;
      if (rd_fire && {araddr[7:2], 2'b00} == OFS_RX_B) hold_v[3] <= 1'b0;
      for (int s = 0; s < 4; s++) begin
        if (rise[s/2]) begin
          case (st[s])
            ST_IDLE: begin
              if (go[s] && frm[s] && !cf[s][F_LATE]) begin
                st[s] <= ST_PEND;
                fs_drv[s] <= 1'b1;
              end else if (go[s]) begin
                st[s] <= ST_SHIFT;
                fs_drv[s] <= frm[s];
                bitc[s] <= wl[s];
              end
            end
            ST_PEND: begin
              st[s] <= ST_SHIFT;
              fs_drv[s] <= 1'b0;
              bitc[s] <= wl[s];
            end
            ST_SHIFT: begin
              if (s%2 == 0 && bitc[s] == 4'h0) begin
                st[s] <= ST_IDLE;
                fs_drv[s] <= 1'b0;
                fin[s] <= 1'b1;
              end else if (s%2 == 0) begin
                bitc[s] <= bitc[s] - 4'h1;
              end
            end
            default: st[s] <= ST_IDLE;
          endcase
          // Load shifter as the word starts; holding buffer frees up
          if ((st[s] == ST_PEND || (st[s] == ST_IDLE && go[s] &&
               !(frm[s] && !cf[s][F_LATE])))) begin
            if (s%2 == 1) begin
              sh[s] <= 16'h0000;
            end else if (hold_v[s] && !(mc[s] && !mc_tx[slot])) begin
              sh[s] <= ctrl[s/2][F_CMP+1] ?
                       {8'h00, compress(hold[s], ctrl[s/2][F_CMP])} : hold[s];
              hold_v[s] <= 1'b0;
            end else begin
              sh[s] <= 16'h0000;
            end
          end
        end
        if (fall[s/2] && s%2 == 1 && st[s] == ST_SHIFT) begin
          sh[s] <= {sh[s][14:0], filt[(s/2)*4+B_DAT]};
          if (bitc[s] == 4'h0) begin
            st[s] <= ST_IDLE;
            fs_drv[s] <= 1'b0;
            fin[s] <= 1'b1;
            if (!(mc[s] && !mc_rx[slot])) begin
              hold[s] <= ctrl[s/2][F_CMP+1] ?
                         expand({sh[s][6:0], filt[(s/2)*4+B_DAT]}, ctrl[s/2][F_CMP]) :
                         {sh[s][14:0], filt[(s/2)*4+B_DAT]};
              hold_v[s] <= 1'b1;
            end
            if (mc[s]) begin
              slot <= (slot == (ctrl[0][F_MC32] ? SLOT_LAST_32 : SLOT_LAST_24)) ?
                      5'h00 : slot + 5'h01;
            end
          end else begin
            bitc[s] <= bitc[s] - 4'h1;
          end
        end
      end
      // Write in the cycle the old word loads stays pending
      if (wr_fire && aw_addr == OFS_TX_B) begin
        hold[2] <= w_data[15:0];
        hold_v[2] <= 1'b1;
      end
    end
  end

  // Word events; autobuffer counts words and signals once per run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_irq <= 4'h0;
      for (int s = 0; s < 4; s++) begin
        abc[s] <= 8'h00;
      end
    end else begin
      for (int s = 0; s < 4; s++) begin
        word_irq[s] <= 1'b0;
        if (fin[s] && !ctrl[s/2][F_AB]) begin
          word_irq[s] <= 1'b1;
        end else if (fin[s] && abc[s] == ablen[(s/2)*8 +: 8]) begin
          word_irq[s] <= 1'b1;
          abc[s] <= 8'h00;
        end else if (fin[s]) begin
          abc[s] <= abc[s] + 8'h01;
        end
      end
    end
  end

  // Pin drivers; port B can trade serial pins for interrupts and flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_drive <= '0;
      ext_interrupt_line_zero <= 1'b0;
      ext_interrupt_line_one <= 1'b0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        link_drive[p].clk <= sclk_int[p];
        link_drive[p].clk_oe <= ctrl[p][F_ISCLK];
        link_drive[p].tx_sync <= fs_drv[2*p] ^ ctrl[p][F_INV];
        link_drive[p].tx_sync_oe <= ctrl[p][F_IFS] && ctrl[p][F_FRM] && !mc[2*p] &&
                                    !(p == 1 && ctrl[1][F_ALT]);
        link_drive[p].rx_sync <= fs_drv[2*p+1] ^ ctrl[p][SEC_W+F_INV];
        link_drive[p].rx_sync_oe <= ctrl[p][SEC_W+F_IFS] && ctrl[p][SEC_W+F_FRM] &&
                                    !(p == 1 && ctrl[1][F_ALT]);
        link_drive[p].data <= (p == 1 && ctrl[1][F_ALT]) ? flag_out : sh[2*p][bitc[2*p]];
        link_drive[p].data_oe <= (p == 1 && ctrl[1][F_ALT]) ||
                                 (st[2*p] == ST_SHIFT && !(mc[2*p] && !mc_tx[slot]));
      end
      ext_interrupt_line_zero <= ctrl[1][F_ALT] & filt[4+B_RXS];
      ext_interrupt_line_one <= ctrl[1][F_ALT] & filt[4+B_TXS];
    end
  end
endmodule

// *** core/serial_port_pkg.sv ***
// Constants, types and register map of the dual serial port block.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register bus.
package serial_port_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_DIV_A = 8'h08;
  localparam logic [7:0] OFS_DIV_B = 8'h0c;
  localparam logic [7:0] OFS_TX_A = 8'h10;
  localparam logic [7:0] OFS_TX_B = 8'h14;
  localparam logic [7:0] OFS_RX_A = 8'h18;
  localparam logic [7:0] OFS_RX_B = 8'h1c;
  localparam logic [7:0] OFS_STAT = 8'h20;
  localparam logic [7:0] OFS_MC_TX = 8'h24;
  localparam logic [7:0] OFS_MC_RX = 8'h28;
  localparam logic [7:0] OFS_ABLEN = 8'h2c;
  localparam logic [7:0] OFS_FLAG = 8'h30;
  // Section field positions, tx section at 0, rx section at SEC_W
  localparam int F_EN = 0;
  localparam int F_FRM = 1;
  localparam int F_IFS = 2;
  localparam int F_INV = 3;
  localparam int F_LATE = 4;
  localparam int F_WL = 5;
  localparam int SEC_W = 9;
  // Port-wide fields
  localparam int F_ISCLK = 18;
  localparam int F_CMP = 19;
  localparam int F_AB = 21;
  localparam int F_ALT = 22;
  localparam int F_MC32 = 23;
  // Reset values and other constants
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] DIV_RST = 16'h0003;
  localparam logic [3:0] WL_COMPAND = 4'h7;
  localparam logic [4:0] SLOT_LAST_24 = 5'h17;
  localparam logic [4:0] SLOT_LAST_32 = 5'h1f;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Bit positions of one port's sensed pins
  localparam int B_CLK = 3;
  localparam int B_TXS = 2;
  localparam int B_RXS = 1;
  localparam int B_DAT = 0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PEND = 2'b01,
    ST_SHIFT = 2'b10
  } sec_state_t;

  typedef struct packed {
    logic clk;
    logic tx_sync;
    logic rx_sync;
    logic data;
  } link_sense_t;

  typedef struct packed {
    logic clk;
    logic clk_oe;
    logic tx_sync;
    logic tx_sync_oe;
    logic rx_sync;
    logic rx_sync_oe;
    logic data;
    logic data_oe;
  } link_drive_t;
endpackage

// *** sim/link_partner.sv ***
// Far-side model: a codec that clocks port A and listens on both ports.
// Assumes the bench resolves no pins itself; this model does it.
`timescale 1ns/1ps
module link_partner
  import serial_port_pkg::*;
(
  // Bench control
  input wire logic run_a,
  input wire logic [3:0] sync_in,
  // Pins
  input wire serial_port_pkg::link_drive_t [1:0] drv,
  output wire serial_port_pkg::link_sense_t [1:0] sense,
  // Last bits heard
  output logic [15:0] cap_a,
  output logic [15:0] cap_b
);
  logic sclk_a;
  logic [1:0] last = 2'b01;
  // 80 ns clock, parked low between bursts
  initial begin
    sclk_a = 1'b0;
    #3;
    forever #40 if (run_a || sclk_a) sclk_a = ~sclk_a;
  end
  always @* begin
    for (int i = 0; i < 2; i++) begin
      if (drv[i].data_oe) last[i] = drv[i].data;
    end
  end
  for (genvar i = 0; i < 2; i++) begin : g_pin
    assign sense[i].clk = drv[i].clk_oe ? drv[i].clk : (i == 0 && sclk_a);
    assign sense[i].tx_sync = drv[i].tx_sync_oe ? drv[i].tx_sync : sync_in[2*i+1];
    assign sense[i].rx_sync = drv[i].rx_sync_oe ? drv[i].rx_sync : sync_in[2*i];
    // Released data line shows the inverse of its last level
    assign sense[i].data = drv[i].data_oe ? drv[i].data : ~last[i];
  end
  // Port A bits change late after our rise; port B mid-bit on the fall
  always @(posedge sense[0].clk) if (drv[0].data_oe) cap_a <= {cap_a[14:0], sense[0].data};
  always @(negedge sense[1].clk) if (drv[1].data_oe) cap_b <= {cap_b[14:0], sense[1].data};
endmodule

// *** sim/dual_serial_port_monitor.sv ***
// Checker for the register bus and event outputs of the serial block.
// Assumes one aclk domain; bound to the top module below.
`timescale 1ns/1ps
module dual_serial_port_monitor
  import serial_port_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Link and events
  input wire serial_port_pkg::link_drive_t [1:0] link_drive,
  input wire logic [3:0] word_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire w_go = awvalid && awready && wvalid && wready && !bvalid;
  bvalid_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("bvalid or bresp moved before bready");
  rvalid_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("rvalid or rdata moved before rready");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered one cycle after address");
  read_block_a: assert property (rvalid |-> !arready)
    else $error("read address accepted while answer pending");
  bad_read_a: assert property (arvalid && arready && araddr[7:2] > 6'hc
    |=> rresp == RESP_SLVERR && rdata == 32'h0) else $error("unmapped read not refused");
  good_read_a: assert property (arvalid && arready && araddr[7:2] <= 6'hc
    |=> rresp == RESP_OKAY) else $error("mapped read refused");
  write_answer_a: assert property (w_go && awaddr[7:2] != 6'h4 |-> ##[1:3] bvalid)
    else $error("write response late");
  irq_pulse_a: assert property (word_irq != 4'h0 |=> (word_irq & $past(word_irq)) == 4'h0)
    else $error("word event longer than one cycle");
  tx_done_a: assert property (word_irq[2] |-> !link_drive[1].data_oe)
    else $error("port B tx event while data still driven");
  reset_quiet_a: assert property (disable iff (1'b0) !aresetn
    |=> link_drive == '0 && word_irq == 4'h0 && !bvalid && !rvalid)
    else $error("outputs active after reset");
  cover property (word_irq[0]);
  cover property (word_irq[2]);
  cover property (rvalid && rresp == RESP_SLVERR);
endmodule

bind dual_serial_port dual_serial_port_monitor mon (.aclk(aclk), .aresetn(aresetn),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .link_drive(link_drive), .word_irq(word_irq));

// *** sim/testbench.sv ***
// Self-checking bench for the dual serial port block.
// Assumes the partner model and the bound checker beside it.
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module testbench;
  import serial_port_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ext0, ext1, run_a;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, word_irq, sync_in;
  logic [1:0] bresp, rresp, r;
  logic [15:0] cap_a, cap_b;
  link_sense_t [1:0] sense;
  link_drive_t [1:0] drv;
  int fails = 0;
  int compares = 0;
  int irq_a = 0;
  int irq_b = 0;
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (word_irq[0]) irq_a++;
    if (word_irq[2]) irq_b++;
  end
  dual_serial_port #(.TX_FIFO_DEPTH(32)) DUT (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .link_sense(sense), .link_drive(drv),
    .word_irq(word_irq), .ext_interrupt_line_zero(ext0), .ext_interrupt_line_one(ext1));
  link_partner LP (.run_a(run_a), .sync_in(sync_in), .drv(drv), .sense(sense),
    .cap_a(cap_a), .cap_b(cap_b));
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw;
    logic w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK("rdata", e, d)
  endtask
  task automatic wait_cnt(ref int c, input int t);
    for (int n = 0; n < 5000 && c < t; n++) @(posedge aclk);
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #300000;
    fails++;
    finish_test;
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, run_a} = '0;
    {awaddr, araddr, wdata, sync_in} = '0;
    wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(OFS_CTRL_A, CTRL_RST);
    rchk(OFS_DIV_B, {16'h0, DIV_RST});
    wr(OFS_MC_TX, 32'h00ff_00ff);
    rchk(OFS_MC_TX, 32'h00ff_00ff);
    rd(8'h34);
    `CHK("rresp", RESP_SLVERR, r)
    `CHK("rdata", 32'h0, d)
    wr(8'h34, 32'h1);
    `CHK("bresp", RESP_SLVERR, r)
    // Port B: 16-bit words, internal clock, run of two words
    wr(OFS_ABLEN, 32'h0000_0100);
    wr(OFS_CTRL_B, 32'h0024_01e1);
    wr(OFS_TX_B, 32'h0000_c3a5);
    do rd(OFS_STAT); while (d[6]);
    wr(OFS_TX_B, 32'h0000_5a3c);
    wait_cnt(irq_b, 1);
    `CHK("cap_b", 16'h5a3c, cap_b)
    repeat (300) @(posedge aclk);
    `CHK("irq_b", 1, irq_b)
    // Port B pins as interrupt lines and flags
    wr(OFS_CTRL_B, 32'h0044_0000);
    wr(OFS_FLAG, 32'h1);
    sync_in <= 4'b0100;
    repeat (8) @(posedge aclk);
    `CHK("ext0", 1'b1, ext0)
    `CHK("ext1", 1'b0, ext1)
    `CHK("flag_out", 1'b1, drv[1].data)
    `CHK("sclk_oe", 1'b1, drv[1].clk_oe)
    rd(OFS_STAT);
    `CHK("flag_in", 1'b1, d[9])
    sync_in <= 4'b1000;
    repeat (8) @(posedge aclk);
    `CHK("ext1", 1'b1, ext1)
    wr(OFS_CTRL_B, 32'h0);
    @(posedge aclk);
    `CHK("ext1", 1'b0, ext1)
    // Port B: mu-law compressed 8-bit word
    wr(OFS_CTRL_B, 32'h0014_0001);
    wr(OFS_TX_B, 32'h0000_4000);
    wait_cnt(irq_b, 2);
    `CHK("cap_b", 8'h8f, cap_b[7:0])
    // Port A: 3-bit words, external clock held until the FIFO is full
    wr(OFS_CTRL_A, 32'h0000_0041);
    for (int i = 0; i < 33; i++) wr(OFS_TX_A, 32'(i));
    rd(OFS_STAT);
    `CHK("fifo_full", 1'b1, d[8])
    fork
      wr(OFS_TX_A, 32'h5);
      begin
        repeat (30) @(posedge aclk);
        `CHK("bvalid", 1'b0, bvalid)
        run_a <= 1'b1;
      end
    join
    wait_cnt(irq_a, 34);
    run_a <= 1'b0;
    `CHK("irq_a", 34, irq_a)
    `CHK("cap_a", 3'h5, cap_a[2:0])
    rd(OFS_STAT);
    `CHK("fifo_full", 1'b0, d[8])
    finish_test;
  end
endmodule
